// ==== bench/pickup_partner.sv ====
module pickup_partner
(
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_block_req,
  output logic      o_cycle_tick,
  output logic      o_block_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q;
  // One processing cycle every eight clocks from the measurement chain.
  // The blocking level only moves right after a tick, so it leads the next decision by a full cycle.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_q <= 3'h0;
      o_cycle_tick <= 1'b0;
      o_block_in <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 3'h1;
      o_cycle_tick <= (div_q == 3'h7);
      if (o_cycle_tick)
      begin
        o_block_in <= i_block_req;
      end
    end
  end
endmodule

// ==== bench/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pickup_stage_pkg::*;
  logic clk, rstn, tick, blk, blk_req, clr_set, clr_in, fdm;
  logic st, bl, tr, trl, tmr, dev, bev, ccmd;
  logic st_u, bl_u;
  logic [MAG_W-1:0] mag, thr, emag;
  logic [DLY_W-1:0] dly;
  logic [FAULT_W-1:0] flt, eflt;
  logic [31:0] seed, r;
  int error_cnt, total_checks, ev_cnt, disp_cnt, clr_cnt;
  ////////////////////////////////////////////////////////////////////////
  pickup_partner far_u (.i_core_clk(clk), .i_rstn(rstn), .i_block_req(blk_req),
                        .o_cycle_tick(tick), .o_block_in(blk));
  pickup_stage dut_u (.i_core_clk(clk), .i_rstn(rstn), .i_cycle_tick(tick), .i_measured_magnitude(mag),
    .i_pickup_threshold(thr), .i_op_delay(dly), .i_fixed_delay_mode(fdm), .i_block_in(blk),
    .i_fault_type(flt), .i_latch_clear_set(clr_set), .i_latch_clear_in(clr_in), .o_start(st),
    .o_blocked(bl), .o_trip(tr), .o_trip_latched(trl), .o_timer_run(tmr), .o_display_event(dev),
    .o_block_event(bev), .o_event_magnitude(emag), .o_event_fault(eflt), .o_latch_clear_cmd(ccmd));
  // A second stage built for under-threshold use shares every input with the first.
  pickup_stage #(.UNDER_MODE(1'b1)) dut_under_u (.i_core_clk(clk), .i_rstn(rstn), .i_cycle_tick(tick),
    .i_measured_magnitude(mag), .i_pickup_threshold(thr), .i_op_delay(dly), .i_fixed_delay_mode(fdm),
    .i_block_in(blk), .i_fault_type(flt), .i_latch_clear_set(clr_set), .i_latch_clear_in(clr_in),
    .o_start(st_u), .o_blocked(bl_u), .o_trip(), .o_trip_latched(), .o_timer_run(), .o_display_event(),
    .o_block_event(), .o_event_magnitude(), .o_event_fault(), .o_latch_clear_cmd());
  ////////////////////////////////////////////////////////////////////////
  // Free-running clock at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Event pulses are counted so that a doubled or missing pulse shows.
  always @(posedge clk)
  begin
    if (bev === 1'b1) ev_cnt++;
    if (dev === 1'b1) disp_cnt++;
    if (ccmd === 1'b1) clr_cnt++;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // An over stage picks up only strictly above its threshold.
  function automatic logic exp_over(input logic [15:0] m, input logic [15:0] t);
    return m > t;
  endfunction
  // A picked-up under stage holds until the magnitude passes 103 percent of the threshold.
  function automatic logic exp_under_hold(input logic [15:0] m, input logic [15:0] t);
    return (32'(m) * RESET_RATIO_DEN) <= (32'(t) * UNDER_RATIO_NUM);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Waits for n processing ticks, then lets the two register stages settle.
  task automatic step(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (tick !== 1'b1 && k < 20);
      if (k >= 20)
      begin
        error_cnt++;
        report_and_stop();
      end
    end
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic drive(input logic [15:0] m, input logic [15:0] t);
    @(posedge clk);
    mag <= m;
    thr <= t;
  endtask
  task automatic pulse_clear(input bit use_pin);
    @(posedge clk);
    if (use_pin) clr_in <= 1'b1;
    else clr_set <= 1'b1;
    repeat (3) @(posedge clk);
    clr_in <= 1'b0;
    clr_set <= 1'b0;
    step(1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, blk_req, clr_set, clr_in, flt} = '0;
    {error_cnt, total_checks, ev_cnt, disp_cnt, clr_cnt} = '0;
    mag = 16'h0000;
    thr = 16'h03E8;
    dly = 20'h00004;
    fdm = 1'b1;
    seed = 32'hF9187421;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    drive(16'h03E9, 16'h03E8);
    step(1);
    chk("start", st, 1);
    chk("timer", tmr, 1);
    chk("blocked", bl, 0);
    drive(16'h03CA, 16'h03E8);
    step(1);
    chk("start at 97", st, 1);
    drive(16'h03C9, 16'h03E8);
    step(1);
    chk("start below 97", st, 0);
    $display("test pickup and hysteresis done");
    drive(16'h05DC, 16'h03E8);
    step(1);
    chk("trip early", tr, 0);
    step(5);
    chk("trip", tr, 1);
    drive(16'h0000, 16'h03E8);
    step(1);
    chk("latched", trl, 1);
    pulse_clear(0);
    chk("latch set clear", trl, 0);
    chk("clear pulses", clr_cnt, 1);
    pulse_clear(1);
    chk("clear pin pulses", clr_cnt, 2);
    $display("test delay and clear done");
    drive(16'h05DC, 16'h03E8);
    step(1);
    @(posedge clk);
    flt <= 4'h9;
    blk_req <= 1'b1;
    step(2);
    chk("start dropped", st, 0);
    chk("blocked", bl, 1);
    chk("block events", ev_cnt, 1);
    chk("display events", disp_cnt, 1);
    chk("event fault", eflt, 4'h9);
    chk("event magnitude", emag, 16'h05DC);
    step(6);
    chk("no trip blocked", tr, 0);
    $display("test blocking done");
    @(posedge clk);
    blk_req <= 1'b0;
    dly <= 20'h00000;
    drive(16'h0000, 16'h03E8);
    step(3);
    drive(16'h07D0, 16'h03E8);
    step(1);
    chk("zero delay start", st, 1);
    chk("zero delay trip", tr, 1);
    // Inverse mode has no delayed trip path in this stage (only a zero delay trips), so the stage starts but never trips here.
    @(posedge clk);
    fdm <= 1'b0;
    dly <= 20'h00004;
    drive(16'h0000, 16'h03E8);
    step(1);
    drive(16'h05DC, 16'h03E8);
    step(6);
    chk("inverse no trip", tr, 0);
    chk("inverse timer", tmr, 1);
    $display("test zero delay and inverse mode done");
    @(posedge clk);
    fdm <= 1'b1;
    dly <= 20'hFFFFF;
    repeat (24)
    begin
      seed = xs(seed);
      r = seed;
      drive(16'h0000, r[31:16] | 16'h0001);
      step(1);
      drive(r[15:0], r[31:16]);
      step(1);
      chk("random start", st, exp_over(r[15:0], r[31:16]));
      chk("random under start", st_u, exp_under_hold(r[15:0], r[31:16]));
      chk("random under blocked", bl_u, 0);
    end
    $display("test random pickup done");
    report_and_stop();
  end
endmodule

// ==== rtl/pickup_stage.sv ====
// Contract
// - Every processing cycle compare measured magnitude with pickup threshold.
// - Once active, release only past 97 percent of threshold; with UNDER_MODE the stage releases only above 103 percent instead.
// - Blocking input is sampled at start of each processing cycle.
// - Blocking comes from one dedicated input of the blocking matrix.
// - Pickup without blocking raises start and runs operate timing.
// - Pickup with blocking raises blocked and does no timing or trip.
// - Blocking after start drops start; release as if pickup reset.
// - Each blocking occurrence gives display notice and stamped event with values.
// - Latch clear command clears latched signals and returns idle itself.
// - Fixed delay mode trips after delay while pickup stays active.
// - Zero delay trips in the same cycle as start.
module pickup_stage
  import pickup_stage_pkg::*;
#(
  parameter bit UNDER_MODE = 1'b0
)
(
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_cycle_tick,
  input  wire logic [MAG_W-1:0]   i_measured_magnitude,
  input  wire logic [MAG_W-1:0]   i_pickup_threshold,
  input  wire logic [DLY_W-1:0]   i_op_delay,
  input  wire logic               i_fixed_delay_mode,
  input  wire logic               i_block_in,
  input  wire logic [FAULT_W-1:0] i_fault_type,
  input  wire logic               i_latch_clear_set,
  input  wire logic               i_latch_clear_in,
  output logic                    o_start,
  output logic                    o_blocked,
  output logic                    o_trip,
  output logic                    o_trip_latched,
  output logic                    o_timer_run,
  output logic                    o_display_event,
  output logic                    o_block_event,
  output logic [MAG_W-1:0]        o_event_magnitude,
  output logic [FAULT_W-1:0]      o_event_fault,
  output logic                    o_latch_clear_cmd
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and comparison.

  logic                   blk_s1_q;
  logic                   blk_s2_q;
  logic                   clr_s1_q;
  logic                   clr_s2_q;
  logic                   pick_q;
  logic                   pick_d;
  stage_state_t           state_q;
  stage_state_t           state_d;
  logic [DLY_W-1:0]       cnt_q;
  logic [DLY_W-1:0]       cnt_d;
  logic [DLY_W-1:0]       cnt_next;
  logic [MAG_W-1:0]       start_mag_q;
  logic                   clear_cmd_q;
  logic [MAG_W+7:0]       rel_level;
  logic [MAG_W+7:0]       mag_scaled;
  logic                   over_set;
  logic                   past_release;
  logic                   blocked_now;
  logic                   delay_done;
  logic                   clear_any;

  // The blocking pin and the clear pin input come from outside and pass two flops first.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
      clr_s1_q <= 1'b0;
      clr_s2_q <= 1'b0;
    end
    else
    begin
      blk_s1_q <= i_block_in;
      blk_s2_q <= blk_s1_q;
      clr_s1_q <= i_latch_clear_in;
      clr_s2_q <= clr_s1_q;
    end
  end

  // Scaling the magnitude by 100 and the threshold by 97 (103 in under mode) avoids a divider at the cost of wider compares.
  assign rel_level  = (MAG_W+8)'(i_pickup_threshold) *
                      (MAG_W+8)'(UNDER_MODE ? UNDER_RATIO_NUM : RESET_RATIO_NUM);
  assign mag_scaled = (MAG_W+8)'(i_measured_magnitude) * (MAG_W+8)'(RESET_RATIO_DEN);
  assign over_set   = UNDER_MODE ? (i_measured_magnitude < i_pickup_threshold)
                                 : (i_measured_magnitude > i_pickup_threshold);
  assign past_release = UNDER_MODE ? (mag_scaled > rel_level) : (mag_scaled < rel_level);
  assign pick_d     = pick_q ? !past_release : over_set;
  assign blocked_now = blk_s2_q;
  // The count that this tick would reach decides the trip, so a delay of D ticks trips on the D-th tick.
  assign cnt_next   = cnt_q + DLY_W'(1);
  assign delay_done = (cnt_next >= i_op_delay);
  assign clear_any  = i_latch_clear_set | clr_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Stage state machine, advanced once per processing cycle tick.

  // Blocking is read before the pickup decision of the same tick is used.
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE:
      begin
        cnt_d = DLY_RESET;
        if (pick_d && blocked_now)
          state_d = ST_BLOCKED;
        else if (pick_d)
          state_d = (i_op_delay == DLY_RESET) ? ST_TRIPPED : ST_STARTED;
      end
      ST_STARTED:
      begin
        cnt_d = cnt_next;
        if (!pick_d || blocked_now)
        begin
          state_d = blocked_now && pick_d ? ST_BLOCKED : ST_IDLE;
          cnt_d   = DLY_RESET;
        end
        else if (i_fixed_delay_mode && delay_done)
          state_d = ST_TRIPPED;
      end
      ST_BLOCKED:
      begin
        cnt_d = DLY_RESET;
        if (!pick_d)
          state_d = ST_IDLE;
        else if (!blocked_now)
          state_d = (i_op_delay == DLY_RESET) ? ST_TRIPPED : ST_STARTED;
      end
      ST_TRIPPED:
      begin
        cnt_d = DLY_RESET;
        if (!pick_d)
          state_d = ST_IDLE;
        else if (blocked_now)
          state_d = ST_BLOCKED;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State, counter and pickup memory only move on a processing tick.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= DLY_RESET;
      pick_q  <= 1'b0;
    end
    else if (i_cycle_tick)
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pick_q  <= pick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs and events.

  // The trip latch holds until a clear; a fresh trip in the clear cycle wins.
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_start           <= 1'b0;
      o_blocked         <= 1'b0;
      o_trip            <= 1'b0;
      o_trip_latched    <= 1'b0;
      o_timer_run       <= 1'b0;
      o_display_event   <= 1'b0;
      o_block_event     <= 1'b0;
      o_event_magnitude <= '0;
      o_event_fault     <= '0;
      o_latch_clear_cmd <= 1'b0;
      start_mag_q       <= '0;
      clear_cmd_q       <= 1'b0;
    end
    else
    begin
      o_start     <= (state_q == ST_STARTED) || (state_q == ST_TRIPPED);
      o_blocked   <= (state_q == ST_BLOCKED);
      o_trip      <= (state_q == ST_TRIPPED);
      o_timer_run <= (state_q == ST_STARTED);
      if (state_q == ST_TRIPPED)
        o_trip_latched <= 1'b1;
      else if (clear_any)
        o_trip_latched <= 1'b0;
      if (i_cycle_tick && state_q == ST_IDLE && pick_d)
        start_mag_q <= i_measured_magnitude;
      o_display_event <= i_cycle_tick && state_d == ST_BLOCKED && state_q != ST_BLOCKED;
      o_block_event   <= i_cycle_tick && state_d == ST_BLOCKED && state_q != ST_BLOCKED;
      if (i_cycle_tick && state_d == ST_BLOCKED && state_q != ST_BLOCKED)
      begin
        o_event_magnitude <= (state_q == ST_IDLE) ? i_measured_magnitude : start_mag_q;
        o_event_fault     <= i_fault_type;
      end
      // One-shot: the command pulses once and returns to idle by itself.
      clear_cmd_q       <= clear_any;
      o_latch_clear_cmd <= clear_any && !clear_cmd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  excl_ind_a: assert property (!(o_start && o_blocked))
    else $error("start and blocked both high");
  block_no_trip_a: assert property (state_q == ST_BLOCKED |=> !o_trip)
    else $error("trip while blocked");
  block_drop_a: assert property ((state_q == ST_STARTED) && i_cycle_tick && blocked_now |=> state_q != ST_STARTED)
    else $error("start did not drop on block");
  block_evt_a: assert property (o_block_event |-> o_display_event)
    else $error("block event without display event");
  clear_pulse_a: assert property (o_latch_clear_cmd |=> !o_latch_clear_cmd)
    else $error("clear command stuck");
  clear_latch_a: assert property (clear_any && state_q != ST_TRIPPED |=> !o_trip_latched)
    else $error("latch not cleared");
  zero_dly_a: assert property (state_q == ST_IDLE && i_cycle_tick && pick_d && !blocked_now
                               && i_op_delay == DLY_RESET |=> state_q == ST_TRIPPED)
    else $error("zero delay did not trip at once");
  start_go_a: assert property (state_q == ST_IDLE && i_cycle_tick && pick_d && !blocked_now
                               && i_op_delay != DLY_RESET |=> ##1 o_start)
    else $error("pickup did not start");
  pick_hold_a: assert property (pick_q && i_cycle_tick && !past_release |=> pick_q)
    else $error("pickup released inside hysteresis");

  cov_trip_c:  cover property (o_trip);
  cov_block_c: cover property (o_block_event);
  cov_drop_c:  cover property (o_start ##1 o_blocked);
  cov_clear_c: cover property (o_latch_clear_cmd);

endmodule

// ==== rtl/pickup_stage_pkg.sv ====
package pickup_stage_pkg;

  // Magnitudes and thresholds are unsigned fixed-point values of this width.
  localparam int unsigned MAG_W = 16;
  // Delay counter width, in processing cycles.
  localparam int unsigned DLY_W = 20;
  // Fault type code width carried in the blocking event.
  localparam int unsigned FAULT_W = 4;

  // Release level is threshold * 97 / 100.
  localparam int unsigned RESET_RATIO_NUM = 97;
  localparam int unsigned RESET_RATIO_DEN = 100;
  // Mirrored ratio for under-threshold use: threshold * 103 / 100.
  localparam int unsigned UNDER_RATIO_NUM = 103;

  // Minimum blocking lead time demanded of the blocking source.
  localparam int unsigned BLOCK_LEAD_MS = 5;
  localparam int unsigned CLK_HZ = 100_000_000;

  // Reset values.
  localparam logic [DLY_W-1:0] DLY_RESET = 20'h00000;

  // Stage states.
  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_STARTED = 2'b01,
    ST_BLOCKED = 2'b10,
    ST_TRIPPED = 2'b11
  } stage_state_t;

endpackage
